// ---- qdec_array.sv ----
// Array decoder: chip-set select and unselected flag per pattern
`timescale 1ns/1ns
module qdec_array (
  qdec_dec_if.dec_mp d
);
  logic [2:0] idx;
  logic       over;

  // Select field and overflow field move up with device size
  always_comb
  begin
    unique case (d.pattern) // [R10]
      qdec_pkg::PAT_HALF_2K:
      begin
        idx  = {1'b0, d.dec_bits[1:0]};  // [R18]
        over = |d.dec_bits[6:2];
      end
      qdec_pkg::PAT_FULL_2K:
      begin
        idx  = d.dec_bits[2:0];          // [R11]
        over = |d.dec_bits[6:3];
      end
      qdec_pkg::PAT_FULL_4K:
      begin
        idx  = d.dec_bits[3:1];          // [R11]
        over = |d.dec_bits[6:4];
      end
      qdec_pkg::PAT_FULL_8K:
      begin
        idx  = d.dec_bits[4:2];          // [R11]
        over = |d.dec_bits[6:5];
      end
    endcase
  end

  // Empty socket counts as unselected, same as a capacity overrun
  assign d.unsel = over | ~d.socket[idx]; // [R12]
  assign d.cs    = over ? 8'h00 : (8'h01 << idx);
endmodule

// ---- qdec_dec_if.sv ----
// Signals between the decoder top and its normalizer and array decoder
`timescale 1ns/1ns
interface qdec_dec_if;
  logic [qdec_pkg::HI_W-1:0]  bus_hi;
  logic [qdec_pkg::HI_W-1:0]  start;
  logic                       page_mode;
  logic [qdec_pkg::HI_W-1:0]  norm;
  logic                       below;
  logic                       oor_hi;
  logic [qdec_pkg::DEC_W-1:0] dec_bits;
  logic [1:0]                 pattern;
  logic [qdec_pkg::CS_N-1:0]  socket;
  logic [qdec_pkg::CS_N-1:0]  cs;
  logic                       unsel;
  modport norm_mp (input bus_hi, start, page_mode, output norm, below, oor_hi);
  modport dec_mp  (input dec_bits, pattern, socket, output cs, unsel);
  modport top_mp  (output bus_hi, start, page_mode, dec_bits, pattern, socket,
                   input norm, below, oor_hi, cs, unsel);
endinterface

// ---- qdec_master.sv ----
// Bus master model that runs word transfers toward the decoder
`timescale 1ns/1ns
module qdec_master (
  input  wire logic        clk_i,
  input  wire logic        rply_i,
  input  wire logic [15:0] rdata_i,
  output logic      [21:0] dal_o,
  output logic             sync_o,
  output logic             din_o,
  output logic             dout_o,
  output logic             bbs7_o
);
  initial {dal_o, sync_o, din_o, dout_o, bbs7_o} = '0;
  // One transfer; got_o stays low when no reply comes, like a bus timeout
  task automatic xfer(input logic [21:0] a, input logic wr, input logic [15:0] wd,
                      output logic got_o, output logic [15:0] rd_o);
    int n;
    n = 0;
    @(posedge clk_i);
    dal_o  <= a;
    bbs7_o <= &a[21:12];
    @(posedge clk_i);
    sync_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    if (wr)
      dal_o <= {6'h00, wd};
    din_o  <= !wr;
    dout_o <= wr;
    do @(negedge clk_i); while (!rply_i && ++n < 80);
    got_o = rply_i;
    rd_o  = rdata_i;
    @(posedge clk_i);
    din_o  <= 1'b0;
    dout_o <= 1'b0;
    n = 0;
    do @(negedge clk_i); while (rply_i && ++n < 20);
    @(posedge clk_i);
    sync_o <= 1'b0;
    dal_o  <= ~dal_o; // Released lines never keep their last value
    bbs7_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ---- qdec_norm.sv ----
// Address normalizer and coarse range check
`timescale 1ns/1ns
module qdec_norm (
  qdec_dec_if.norm_mp n
);
  localparam int DEC_HI = qdec_pkg::DEC_W;
  logic [qdec_pkg::HI_W:0] diff;

  // Borrow out of the subtraction marks an address below the start
  assign diff     = {1'b0, n.bus_hi} - {1'b0, n.start}; // [R4]
  assign n.norm   = diff[qdec_pkg::HI_W-1:0];
  assign n.below  = diff[qdec_pkg::HI_W];
  // Page mode spans 4 KB, so every normalized bit must be clear
  assign n.oor_hi = n.page_mode ? (|diff[qdec_pkg::HI_W-1:0])       // [R15]
                                : (|diff[qdec_pkg::HI_W-1:DEC_HI]); // [R6]
endmodule

// ---- qdec_pkg.sv ----
// Constants, field positions and types shared by the window address decoder
// Functional notes
// [R1] Decode the address as soon as it is stable, not at SYNC.
// [R2] Latch on SYNC; out-of-range cycles get no reply and no bus drive.
// [R3] Page/direct switch picks page or direct addressing.
// [R4] Normalized address is bus bits 12-21 minus start switch bits 12-21.
// [R5] Direct mode: bus bits 0-11 go straight to array bits 0-11.
// [R6] Direct mode: bits 12-18 to decoder; any of bits 19-21 is out-of-range.
// [R7] Valid access asserts RPLY; reads drive array data, writes take bus data.
// [R8] Bits 12-21 all ones or BBS7 mean I/O page, never an array access.
// [R9] Normalized bits 12-15 feed the array and, with 16-18, the decoder; the code feeds normalized bits 12-17 to the array.
// [R10] Pattern 00/01/10/11: half 2K, full 2K, full 4K, full 8K.
// [R11] Full arrays select sets on 12-14, 13-15 or 14-16; higher bits out-of-range.
// [R12] Empty socket or exceeded small array flags unselected, ORed into out-of-range.
// [R13] Page mode windows answer only while page control bit 15 is set.
// [R14] Page mode: bus bits 0-10 pass through; bus bit 11 picks the window.
// [R15] Page mode: any normalized bit 12-21 set ignores the cycle.
// [R16] Window page number replaces array bits 11-17; low byte window 0.
// [R17] Page mode array address is 18 bits, limiting capacity to 256 KB.
// [R18] Page mode half-populated 2K: array bits 12-13 pick one of four sets.
// [R19] Page mode combines the normalized check with the decoder check.
// [R20] Page control bit 7 unused, bit 15 is the window enable.
// [R21] Power-up and bus restart clear the page control register.
// [R22] Closed windows give no reply, so the master times out.
package qdec_pkg;
  localparam int BUS_AW      = 22;
  localparam int HI_LSB      = 12;
  localparam int HI_W        = 10;
  localparam int DATA_W      = 16;
  localparam int ARR_AW      = 18;
  localparam int DEC_W       = 7;
  localparam int CS_N        = 8;
  localparam int PAGE_W      = 7;
  localparam int WIN_BIT     = 11;
  localparam int IO_OFS_W    = 13;
  localparam int PCR_SEL_W   = 4;
  // Page control register fields
  localparam int PCR_WIN0_LSB = 0;
  localparam int PCR_WIN1_LSB = 8;
  localparam int PCR_EN_BIT   = 15;
  localparam logic [DATA_W-1:0] PCR_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PCR_MASK  = 16'hff7f;
  // Offset of the page control register group inside the I/O page; bit 12 set
  // because addresses with bits 12-21 all ones count as I/O page
  localparam logic [IO_OFS_W-1:0] PCR_IO_BASE = 13'h1e00;
  // Array decoder patterns
  localparam logic [1:0] PAT_HALF_2K = 2'h0;
  localparam logic [1:0] PAT_FULL_2K = 2'h1;
  localparam logic [1:0] PAT_FULL_4K = 2'h2;
  localparam logic [1:0] PAT_FULL_8K = 2'h3;
  // Array read access time and derived wait, rounded up
  localparam int CLK_MHZ        = 100;
  localparam int ARRAY_ACCESS_NS = 450;
  localparam int ARRAY_WAIT_CYC = (ARRAY_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 6;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_READ, ST_REPLY, ST_WAIT_END
  } qdec_state_t;
endpackage

// ---- qdec_properties.sv ----
// Concurrent checks on the ports of the window address decoder
`timescale 1ns/1ns
module qdec_properties (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [21:0] bus_dal_i,
  input wire logic        bus_dal_oe_o,
  input wire logic        bus_sync_i,
  input wire logic        bus_din_i,
  input wire logic        bus_dout_i,
  input wire logic        bus_bbs7_i,
  input wire logic        bus_rply_o,
  input wire logic        page_mode_i,
  input wire logic [9:0]  start_addr_i,
  input wire logic [7:0]  array_cs_o,
  input wire logic        array_rd_o,
  input wire logic        array_wr_o
);
  localparam int RD_MIN = 44;
  localparam int RD_MAX = 48;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic [10:0] dif;
  logic        oor;
  logic        quiet_ff;
  // Own range check; bit 10 is the borrow of an address below the start
  assign dif = {1'b0, bus_dal_i[21:12]} - {1'b0, start_addr_i};
  assign oor = dif[10] | (page_mode_i ? |dif[9:0] : |dif[9:7]);
  // Held to SYNC low, so the two-cycle pin synchroniser needs no offset
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      quiet_ff <= 1'b0;
    else if (!bus_sync_i)
      quiet_ff <= 1'b0;
    else if (!$past(bus_sync_i) && oor && !bus_bbs7_i)
      quiet_ff <= 1'b1;
  // Array read: reply only after the access wait
  sequence s_read_done;
    ##[RD_MIN:RD_MAX] $rose(bus_rply_o);
  endsequence
  a_oe_with_reply: assert property (bus_dal_oe_o |-> bus_rply_o)
    else $error("Data driven without reply");
  a_quiet_cycle: assert property (quiet_ff |-> !bus_rply_o && !bus_dal_oe_o)
    else $error("Out of range cycle answered");
  a_reply_cause: assert property ($rose(bus_rply_o) |-> $past(bus_sync_i, 2)
    && ($past(bus_din_i, 2) || $past(bus_dout_i, 2)))
    else $error("Reply without strobe");
  a_read_wait: assert property ($rose(array_rd_o) |-> s_read_done)
    else $error("Read reply off its wait");
  a_write_pulse: assert property (array_wr_o |=> !array_wr_o)
    else $error("Write strobe longer than one cycle");
  a_write_reply: assert property ($rose(array_wr_o) |-> ##[0:2] bus_rply_o)
    else $error("Write without reply");
  a_cs_onehot: assert property (|array_cs_o |-> $onehot(array_cs_o))
    else $error("More than one chip set selected");
  a_reply_release: assert property (bus_rply_o && !bus_din_i && !bus_dout_i
    |-> ##[1:4] !bus_rply_o)
    else $error("Reply held after strobes dropped");
  a_io_not_array: assert property (bus_rply_o && bus_bbs7_i |-> array_cs_o == 8'h00)
    else $error("I/O page access selected the array");
endmodule
bind qdec_top qdec_properties u_props (.clk_i, .reset_i, .bus_dal_i, .bus_dal_oe_o,
  .bus_sync_i, .bus_din_i, .bus_dout_i, .bus_bbs7_i, .bus_rply_o, .page_mode_i,
  .start_addr_i, .array_cs_o, .array_rd_o, .array_wr_o);

// ---- qdec_top.sv ----
// Q-bus slave address decoder for a paged or direct memory array
`timescale 1ns/1ns
module qdec_top (
  input  wire logic                          clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          ce_i,
  // Bus pins
  input  wire logic [qdec_pkg::BUS_AW-1:0]   bus_dal_i,
  output logic      [qdec_pkg::DATA_W-1:0]   bus_dal_o,
  output logic                               bus_dal_oe_o,
  input  wire logic                          bus_sync_i,
  input  wire logic                          bus_din_i,
  input  wire logic                          bus_dout_i,
  input  wire logic                          bus_bbs7_i,
  input  wire logic                          bus_init_i,
  output logic                               bus_rply_o,
  // Configuration switches and jumpers
  input  wire logic                          page_mode_i,
  input  wire logic [qdec_pkg::HI_W-1:0]     start_addr_i,
  input  wire logic [1:0]                    pattern_i,
  input  wire logic [qdec_pkg::PCR_SEL_W-1:0] pcr_sel_i,
  input  wire logic [qdec_pkg::CS_N-1:0]     socket_present_i,
  // Memory array
  output logic      [qdec_pkg::ARR_AW-1:0]   array_addr_o,
  output logic      [qdec_pkg::CS_N-1:0]     array_cs_o,
  output logic                               array_rd_o,
  output logic                               array_wr_o,
  output logic      [qdec_pkg::DATA_W-1:0]   array_wdata_o,
  input  wire logic [qdec_pkg::DATA_W-1:0]   array_rdata_i
);
  localparam int PIN_W = qdec_pkg::BUS_AW + 5 + 1 + qdec_pkg::HI_W + 2
                         + qdec_pkg::PCR_SEL_W + qdec_pkg::CS_N;
  localparam logic [qdec_pkg::CNT_W-1:0] WAIT_LOAD =
    qdec_pkg::CNT_W'(qdec_pkg::ARRAY_WAIT_CYC - 1);

  logic [PIN_W-1:0]                 pin_meta_ff;
  logic [PIN_W-1:0]                 pin_ff;
  logic                             sync_q_ff;
  qdec_pkg::qdec_state_t            state_ff;
  logic [qdec_pkg::DATA_W-1:0]      pcr_ff;
  logic [qdec_pkg::CNT_W-1:0]       cnt_ff;
  logic                             is_pcr_ff;
  logic [qdec_pkg::DATA_W-1:0]      bus_dal_ff;
  logic                             bus_dal_oe_ff;
  logic                             bus_rply_ff;
  logic [qdec_pkg::ARR_AW-1:0]      array_addr_ff;
  logic [qdec_pkg::CS_N-1:0]        array_cs_ff;
  logic                             array_rd_ff;
  logic                             array_wr_ff;
  logic [qdec_pkg::DATA_W-1:0]      array_wdata_ff;

  logic [qdec_pkg::BUS_AW-1:0]      dal_s;
  logic                             sync_s;
  logic                             din_s;
  logic                             dout_s;
  logic                             bbs7_s;
  logic                             init_s;
  logic                             page_s;
  logic [qdec_pkg::HI_W-1:0]        start_s;
  logic [1:0]                       pattern_s;
  logic [qdec_pkg::PCR_SEL_W-1:0]   pcr_sel_s;
  logic [qdec_pkg::CS_N-1:0]        socket_s;
  logic                             win1;
  logic [qdec_pkg::PAGE_W-1:0]      page_num;
  logic [qdec_pkg::ARR_AW-1:0]      arr_addr_w;
  logic                             io_page;
  logic [qdec_pkg::IO_OFS_W-1:0]    pcr_addr;
  logic                             pcr_hit;
  logic                             win_open;
  logic                             array_hit;
  logic                             sync_rise;
  logic                             pcr_wr;
  logic                             rd_done;

  qdec_dec_if dif ();

  qdec_norm u_norm (
    .n (dif.norm_mp)
  );

  qdec_array u_array (
    .d (dif.dec_mp)
  );

  // Every bus and switch pin passes two flops; the first stage is read by nothing else
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pin_meta_ff <= '0;
      pin_ff      <= '0;
    end
    else if (ce_i)
    begin
      pin_meta_ff <= {bus_dal_i, bus_sync_i, bus_din_i, bus_dout_i, bus_bbs7_i,
                      bus_init_i, page_mode_i, start_addr_i, pattern_i,
                      pcr_sel_i, socket_present_i};
      pin_ff      <= pin_meta_ff;
    end
  end

  // Unpack the synchronised pins
  assign {dal_s, sync_s, din_s, dout_s, bbs7_s, init_s, page_s, start_s,
          pattern_s, pcr_sel_s, socket_s} = pin_ff;

  // Decode runs continuously on the live address, ahead of SYNC
  assign dif.bus_hi    = dal_s[qdec_pkg::BUS_AW-1:qdec_pkg::HI_LSB]; // [R1] [R4]
  assign dif.start     = start_s;
  assign dif.page_mode = page_s;
  assign dif.pattern   = pattern_s;
  assign dif.socket    = socket_s;

  // Window select and page number from the page control register
  assign win1     = dal_s[qdec_pkg::WIN_BIT]; // [R14]
  assign page_num = win1 ? pcr_ff[qdec_pkg::PCR_WIN1_LSB +: qdec_pkg::PAGE_W]
                         : pcr_ff[qdec_pkg::PCR_WIN0_LSB +: qdec_pkg::PAGE_W]; // [R16]

  // Array address: page mode only reaches 18 bits, hence the 256 KB limit
  assign arr_addr_w = page_s ? {page_num, dal_s[qdec_pkg::WIN_BIT-1:0]}  // [R14] [R16] [R17]
                             : {dif.norm[5:0], dal_s[qdec_pkg::WIN_BIT:0]}; // [R5] [R9]
  assign dif.dec_bits = page_s ? {1'b0, page_num[qdec_pkg::PAGE_W-1:1]}  // [R19]
                               : dif.norm[qdec_pkg::DEC_W-1:0];          // [R6] [R9]

  // I/O page accesses are kept away from the array entirely
  assign io_page  = bbs7_s | (&dal_s[qdec_pkg::BUS_AW-1:qdec_pkg::HI_LSB]); // [R8]
  assign pcr_addr = qdec_pkg::PCR_IO_BASE + {8'h00, pcr_sel_s, 1'b0};
  assign pcr_hit  = page_s & bbs7_s & (dal_s[qdec_pkg::IO_OFS_W-1:0] == pcr_addr); // [R8]
  assign win_open = ~page_s | pcr_ff[qdec_pkg::PCR_EN_BIT]; // [R13] [R22]
  // Either range check alone is enough to ignore the cycle
  assign array_hit = ~io_page & ~dif.below & ~dif.oor_hi & ~dif.unsel
                     & win_open; // [R3] [R6] [R12] [R15] [R19]

  assign sync_rise = sync_s & ~sync_q_ff;
  assign pcr_wr    = (state_ff == qdec_pkg::ST_ADDR) & dout_s & is_pcr_ff;
  assign rd_done   = (state_ff == qdec_pkg::ST_READ) & (cnt_ff == '0);

  // Page control register; restart clears it just like power-up
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      pcr_ff <= qdec_pkg::PCR_RESET; // [R21]
    else if (ce_i)
    begin
      if (init_s)
        pcr_ff <= qdec_pkg::PCR_RESET; // [R21]
      else if (pcr_wr)
        pcr_ff <= dal_s[qdec_pkg::DATA_W-1:0] & qdec_pkg::PCR_MASK; // [R20]
    end
  end

  // SYNC edge detector on the synchronised level
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      sync_q_ff <= 1'b0;
    else if (ce_i)
      sync_q_ff <= sync_s;
  end

  // Read access counter
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cnt_ff <= '0;
    else if (ce_i)
    begin
      if (state_ff != qdec_pkg::ST_READ)
        cnt_ff <= WAIT_LOAD;
      else if (cnt_ff != '0)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Latch the decode at SYNC so later address changes cannot disturb it
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      array_addr_ff <= '0;
      array_cs_ff   <= '0;
      is_pcr_ff     <= 1'b0;
    end
    else if (ce_i && sync_rise && state_ff == qdec_pkg::ST_IDLE)
    begin
      array_addr_ff <= arr_addr_w;  // [R2]
      array_cs_ff   <= array_hit ? dif.cs : '0;
      is_pcr_ff     <= pcr_hit;
    end
  end

  // Bus cycle sequencer; a missed cycle waits out SYNC silently
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_ff       <= qdec_pkg::ST_IDLE;
      bus_rply_ff    <= 1'b0;
      bus_dal_oe_ff  <= 1'b0;
      bus_dal_ff     <= '0;
      array_rd_ff    <= 1'b0;
      array_wr_ff    <= 1'b0;
      array_wdata_ff <= '0;
    end
    else if (ce_i)
    begin
      array_wr_ff <= 1'b0;
      unique case (state_ff)
        qdec_pkg::ST_IDLE:
        begin
          if (sync_rise)
            state_ff <= (array_hit | pcr_hit) ? qdec_pkg::ST_ADDR
                                              : qdec_pkg::ST_WAIT_END; // [R2] [R22]
        end
        qdec_pkg::ST_ADDR:
        begin
          if (!sync_s)
            state_ff <= qdec_pkg::ST_IDLE;
          else if (din_s && is_pcr_ff)
          begin
            bus_dal_ff    <= pcr_ff;
            bus_dal_oe_ff <= 1'b1;
            bus_rply_ff   <= 1'b1;
            state_ff      <= qdec_pkg::ST_REPLY;
          end
          else if (din_s)
          begin
            array_rd_ff <= 1'b1;
            state_ff    <= qdec_pkg::ST_READ;
          end
          else if (dout_s)
          begin
            array_wdata_ff <= dal_s[qdec_pkg::DATA_W-1:0]; // [R7]
            array_wr_ff    <= ~is_pcr_ff;
            bus_rply_ff    <= 1'b1;                        // [R7]
            state_ff       <= qdec_pkg::ST_REPLY;
          end
        end
        qdec_pkg::ST_READ:
        begin
          if (rd_done)
          begin
            bus_dal_ff    <= array_rdata_i; // [R7]
            bus_dal_oe_ff <= 1'b1;
            bus_rply_ff   <= 1'b1;          // [R7]
            array_rd_ff   <= 1'b0;
            state_ff      <= qdec_pkg::ST_REPLY;
          end
        end
        qdec_pkg::ST_REPLY:
        begin
          // Hold the reply until the master drops its strobe
          if (!din_s && !dout_s)
          begin
            bus_rply_ff   <= 1'b0;
            bus_dal_oe_ff <= 1'b0;
            state_ff      <= qdec_pkg::ST_WAIT_END;
          end
        end
        qdec_pkg::ST_WAIT_END:
        begin
          if (!sync_s)
            state_ff <= qdec_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign bus_dal_o     = bus_dal_ff;
  assign bus_dal_oe_o  = bus_dal_oe_ff;
  assign bus_rply_o    = bus_rply_ff;
  assign array_addr_o  = array_addr_ff;
  assign array_cs_o    = array_cs_ff;
  assign array_rd_o    = array_rd_ff;
  assign array_wr_o    = array_wr_ff;
  assign array_wdata_o = array_wdata_ff;
endmodule

// ---- tb.sv ----
// Self-checking bench for the window address decoder
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic pm; logic [9:0] st; logic [1:0] pat; logic [7:0] sock; logic [21:0] a;
    logic wr; logic [15:0] wd; logic rp; logic [17:0] aa; logic [7:0] cs;
  } qdec_row_t;
  logic        clk_i, reset_i, ce_i, bus_sync_i, bus_din_i, bus_dout_i, bus_bbs7_i;
  logic        bus_init_i, page_mode_i, bus_dal_oe_o, bus_rply_o, array_rd_o, array_wr_o;
  logic [21:0] bus_dal_i;
  logic [15:0] bus_dal_o, array_wdata_o, array_rdata_i, got_wd;
  logic [9:0]  start_addr_i;
  logic [1:0]  pattern_i;
  logic [3:0]  pcr_sel_i;
  logic [7:0]  socket_present_i, array_cs_o, got_cs;
  logic [17:0] array_addr_o, got_aa;
  int          err_count, n_compared, cyc;
  // Direct mode rows: start at 10'h010 unless stated
  localparam qdec_row_t ROWS [14] = '{
    '{0, 10'h010, 2'h1, 8'hff, 22'h010abc, 0, 16'h0, 1, 18'h00abc, 8'h01},
    '{0, 10'h010, 2'h1, 8'hff, 22'h015123, 0, 16'h0, 1, 18'h05123, 8'h20},
    '{0, 10'h010, 2'h1, 8'hff, 22'h018000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h1, 8'hff, 22'h00f000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h1, 8'hff, 22'h090000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h0, 8'hff, 22'h013000, 0, 16'h0, 1, 18'h03000, 8'h08},
    '{0, 10'h010, 2'h0, 8'hff, 22'h014000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h2, 8'hff, 22'h016000, 0, 16'h0, 1, 18'h06000, 8'h08},
    '{0, 10'h010, 2'h2, 8'hff, 22'h013000, 0, 16'h0, 1, 18'h03000, 8'h02},
    '{0, 10'h010, 2'h3, 8'hff, 22'h01c000, 0, 16'h0, 1, 18'h0c000, 8'h08},
    '{0, 10'h010, 2'h3, 8'hff, 22'h030000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h1, 8'hfd, 22'h011000, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h3ff, 2'h1, 8'hff, 22'h3ff010, 0, 16'h0, 0, 18'h0, 8'h00},
    '{0, 10'h010, 2'h1, 8'hff, 22'h012456, 1, 16'hbeef, 1, 18'h02456, 8'h04}};
  qdec_top dut (.clk_i, .reset_i, .ce_i, .bus_dal_i, .bus_dal_o, .bus_dal_oe_o,
    .bus_sync_i, .bus_din_i, .bus_dout_i, .bus_bbs7_i, .bus_init_i, .bus_rply_o,
    .page_mode_i, .start_addr_i, .pattern_i, .pcr_sel_i, .socket_present_i,
    .array_addr_o, .array_cs_o, .array_rd_o, .array_wr_o, .array_wdata_o, .array_rdata_i);
  qdec_master m (.clk_i, .rply_i(bus_rply_o), .dal_o(bus_dal_i), .sync_o(bus_sync_i),
    .rdata_i(bus_dal_oe_o ? bus_dal_o : ~bus_dal_o), .din_o(bus_din_i),
    .dout_o(bus_dout_i), .bbs7_o(bus_bbs7_i));
  // Array data outside the read wait is scrambled so a late sample shows
  assign array_rdata_i = array_addr_o[15:0] ^ (array_rd_o ? 16'h5a5a : 16'ha5a5);
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Capture array outputs while the reply stands; timeout guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (bus_rply_o)
      {got_aa, got_cs} <= {array_addr_o, array_cs_o};
    if (array_wr_o)
      got_wd <= array_wdata_o;
    if (cyc == 30000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, g, e);
    end
  endtask
  task automatic run(input qdec_row_t r);
    logic        got;
    logic [15:0] rd;
    {page_mode_i, start_addr_i, pattern_i, socket_present_i} <= {r.pm, r.st, r.pat, r.sock};
    repeat (4) @(posedge clk_i);
    m.xfer(r.a, r.wr, r.wd, got, rd);
    chk(got, r.rp);
    if (got && r.cs != 8'h00)
    begin
      chk(got_aa, r.aa);
      chk(got_cs, r.cs);
    end
    if (got && !r.wr)
      chk(rd, r.cs != 8'h00 ? r.aa[15:0] ^ 16'h5a5a : r.wd);
    if (got && r.wr && r.cs != 8'h00)
      chk(got_wd, r.wd);
  endtask
  // Page mode access, start 10'h010, half-populated pattern
  task automatic pg(input logic [21:0] a, input logic wr, input logic [15:0] wd,
                    input logic rp, input logic [17:0] aa, input logic [7:0] cs);
    run('{1, 10'h010, 2'h0, 8'hff, a, wr, wd, rp, aa, cs});
  endtask
  task automatic summarize();
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {reset_i, ce_i, bus_init_i, page_mode_i, pattern_i, pcr_sel_i} = {3'h6, 7'h00};
    {start_addr_i, socket_present_i, got_wd, got_aa, got_cs} = '0;
    {err_count, n_compared, cyc} = '0;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (ROWS[i])
      run(ROWS[i]);
    pg(22'h3ffe00, 0, 16'h0000, 1, 18'h0, 8'h00);
    pg(22'h3ffe00, 1, 16'h8583, 1, 18'h0, 8'h00);
    pg(22'h3ffe00, 0, 16'h8503, 1, 18'h0, 8'h00);
    pg(22'h010123, 0, 16'h0000, 1, 18'h01923, 8'h02);
    pg(22'h010923, 0, 16'h0000, 1, 18'h02923, 8'h04);
    pg(22'h012000, 0, 16'h0000, 0, 18'h0, 8'h00);
    pg(22'h3ffe00, 1, 16'h8543, 1, 18'h0, 8'h00);
    pg(22'h010123, 0, 16'h0000, 0, 18'h0, 8'h00);
    pg(22'h3ffe00, 1, 16'h0583, 1, 18'h0, 8'h00);
    pg(22'h010923, 0, 16'h0000, 0, 18'h0, 8'h00);
    bus_init_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    bus_init_i <= 1'b0;
    pg(22'h3ffe00, 0, 16'h0000, 1, 18'h0, 8'h00);
    summarize();
  end
endmodule
